// >>> core/sac_pkg.sv
/*
 * constants shared by both ends of the chained slave addressing link.
 * assumes datagram framing and checksum are handled by neighbouring logic.
 */
package sac_pkg;
    localparam int ADDR_W = 8;
    localparam int REG_W = 7;
    localparam int DATA_W = 32;
    localparam logic [7:0] WRITE_FLAG = 8'h80;
    localparam int WRITE_BIT = 7;
    localparam logic [7:0] REPLY_ADDR = 8'hff;
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [7:0] RST_ADDR_HIGH = 8'h01;
    localparam logic RST_RELEASE = 1'b1;
    localparam logic [6:0] CHAIN_REG = 7'h03;
    localparam int CHAIN_ADDR_LSB = 0;
    localparam int CHAIN_LVL_BIT = 8;
    localparam logic [31:0] RST_REG = 32'h0000_0000;
endpackage : sac_pkg

// >>> core/sac_link_if.sv
/*
 * datagram-level link between the bus master and one chained slave.
 * assumes one shared clock; the testbench joins the two ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface sac_link_if;
    logic dg_valid;
    logic [7:0] dg_slave;
    logic [7:0] dg_reg;
    logic [31:0] dg_data;
    logic dg_crc_ok;
    // master side drives the datagram, slave consumes it
    modport master (
        output dg_valid, dg_slave, dg_reg, dg_data, dg_crc_ok
    );
    modport slave (
        input dg_valid, dg_slave, dg_reg, dg_data, dg_crc_ok
    );
endinterface : sac_link_if
`default_nettype wire

// >>> core/sac_master.sv
/*
 * bus master end: turns user write/read requests into datagrams.
 * assumes the user programs devices one at a time along the chain.
 */
`timescale 1ns/10ps
`default_nettype none
module sac_master (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    sac_link_if.master link,
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic [7:0] req_slave_in,
    input wire logic [6:0] req_reg_in,
    input wire logic [31:0] req_data_in,
    output logic req_refused_out
);
    logic valid_ff;
    logic [7:0] slave_ff;
    logic [7:0] reg_ff;
    logic [31:0] data_ff;
    logic refused_ff;
    logic bad_slave;

    // reply address must never be assigned or targeted
    assign bad_slave = (req_slave_in == sac_pkg::REPLY_ADDR);

    // datagram issue; write flag added to register address
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            valid_ff <= 1'b0;
            slave_ff <= 8'h00;
            reg_ff <= 8'h00;
            data_ff <= 32'h0000_0000;
            refused_ff <= 1'b0;
        end else begin
            valid_ff <= req_in && !bad_slave;
            refused_ff <= req_in && bad_slave;
            if (req_in && !bad_slave) begin
                slave_ff <= req_slave_in;
                reg_ff <= req_write_in ?
                    ({1'b0, req_reg_in} | sac_pkg::WRITE_FLAG) :
                    {1'b0, req_reg_in};
                data_ff <= req_data_in;
            end
        end
    end

    assign link.dg_valid = valid_ff;
    assign link.dg_slave = slave_ff;
    assign link.dg_reg = reg_ff;
    assign link.dg_data = data_ff;
    assign link.dg_crc_ok = 1'b1;
    assign req_refused_out = refused_ff;
endmodule : sac_master
`default_nettype wire

// >>> core/sac_slave.sv
/*
 * chained slave end: address selection and chain release output.
 * holds the programmed own address, the release level that frees the
 * next device in the chain, and one-cycle access strobes toward the
 * register map for every datagram that this slave accepts.
 * assumes datagrams arrive already framed with checksum verdict.
 * assumes the select pin is already synchronous to mclk_in.
 * assumes the register map behind the strobes lives elsewhere.
 */
// Summary of operation
// - unprogrammed address follows select pin, 0 or 1
// - eight-bit address covers 255 chained devices
// - drive chain release output at programmed level
// - master programs devices one after another
// - low release level enables external bus switch
// - all registers reset to zero unless noted
// - write flag is bit 0x80 of register address
// - chain release output resets high
// - all-ones address is never own address
// - act only on good checksum, own address
`timescale 1ns/10ps
`default_nettype none
module sac_slave (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    sac_link_if.slave link,
    input wire logic address_select_input_in,
    output logic chain_release_output_out,
    output logic [7:0] slave_addr_out,
    output logic programmed_out,
    output logic wr_stb_out,
    output logic [6:0] wr_reg_out,
    output logic [31:0] wr_data_out,
    output logic rd_stb_out,
    output logic [6:0] rd_reg_out
);
    logic [7:0] chain_address_setting_ff;
    logic release_ff;
    logic programmed_ff;
    logic [7:0] own_addr;
    logic hit;
    logic is_write;
    logic chain_wr;
    logic addr_ok;
    logic wr_ff;
    logic rd_ff;
    logic [6:0] reg_ff;
    logic [31:0] data_ff;
    logic [7:0] addr_out_ff;
    logic [7:0] nxt_addr;
    logic nxt_release;

    // address answered before programming, picked by the select pin
    // only two values exist, so two unchained devices can share a bus
    function automatic logic [7:0] pin_addr(input logic sel);
        if (sel) begin
            return sac_pkg::RST_ADDR_HIGH;
        end else begin
            return sac_pkg::RST_ADDR_LOW;
        end
    endfunction : pin_addr

    // true for any value a slave may take as its own address
    // the all-ones code belongs to replies and is never owned
    function automatic logic own_allowed(input logic [7:0] a);
        if (a == sac_pkg::REPLY_ADDR) begin
            return 1'b0;
        end else begin
            return 1'b1;
        end
    endfunction : own_allowed

    // register index of a datagram with the write flag stripped
    function automatic logic [6:0] reg_index(input logic [7:0] r);
        return r[6:0];
    endfunction : reg_index

    // default address from select pin until programmed
    // the pin is read live, so a late release of the previous
    // device is seen on the very next datagram
    assign own_addr = programmed_ff ? chain_address_setting_ff :
        pin_addr(address_select_input_in);

    // only good datagrams for our own address count
    // foreign, damaged and reply datagrams leave no trace at all
    assign hit = link.dg_valid && link.dg_crc_ok &&
        (link.dg_slave == own_addr) &&
        own_allowed(link.dg_slave);

    // bit seven of the register field marks a write
    assign is_write = link.dg_reg[sac_pkg::WRITE_BIT];

    // accepted write aimed at the chain setting register
    assign chain_wr = hit && is_write &&
        (reg_index(link.dg_reg) == sac_pkg::CHAIN_REG);

    // fields of the chain setting word
    assign nxt_addr = link.dg_data[sac_pkg::CHAIN_ADDR_LSB +: 8];
    assign nxt_release = link.dg_data[sac_pkg::CHAIN_LVL_BIT];

    // reply address refused as new own address, old one stays
    assign addr_ok = own_allowed(nxt_addr);

    // chain address setting; takes effect on next datagram
    // registered, so the datagram that writes it still matches
    // against the address it was sent to
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            chain_address_setting_ff <= sac_pkg::RST_REG[7:0];
        end else if (chain_wr && addr_ok) begin
            chain_address_setting_ff <= nxt_addr;
        end
    end

    // marks that the setting replaces the pin address
    // only reset clears it; a later refused write keeps it set
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            programmed_ff <= 1'b0;
        end else if (chain_wr && addr_ok) begin
            programmed_ff <= 1'b1;
        end
    end

    // low level releases next device or bus switch
    // starts high so every device further down stays at address 1
    // the level follows each chain write, even a refused address
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            release_ff <= sac_pkg::RST_RELEASE;
        end else if (chain_wr) begin
            release_ff <= nxt_release;
        end
    end

    // write strobe, one cycle after an accepted write
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wr_ff <= 1'b0;
        end else begin
            wr_ff <= hit && is_write;
        end
    end

    // read strobe, one cycle after an accepted read
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rd_ff <= 1'b0;
        end else begin
            rd_ff <= hit && !is_write;
        end
    end

    // register index of the last accepted datagram
    // held until the next hit so the map may sample it late
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            reg_ff <= sac_pkg::RST_REG[6:0];
        end else if (hit) begin
            reg_ff <= reg_index(link.dg_reg);
        end
    end

    // write data of the last accepted datagram
    // foreign traffic never disturbs the held word
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            data_ff <= sac_pkg::RST_REG;
        end else if (hit) begin
            data_ff <= link.dg_data;
        end
    end

    // registered copy of the address now answered
    // one cycle behind the live match, shown for observation only
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            addr_out_ff <= sac_pkg::RST_REG[7:0];
        end else begin
            addr_out_ff <= own_addr;
        end
    end

    // every output comes straight from a flip-flop
    assign chain_release_output_out = release_ff;
    assign slave_addr_out = addr_out_ff;
    assign programmed_out = programmed_ff;
    assign wr_stb_out = wr_ff;
    assign rd_stb_out = rd_ff;
    assign wr_reg_out = reg_ff;
    assign rd_reg_out = reg_ff;
    assign wr_data_out = data_ff;
endmodule : sac_slave
`default_nettype wire

// >>> verif/sac_chk.sv
/* checks on the link signals and the slave outputs.
   assumes it is placed beside the link interface in the bench. */
`timescale 1ns/10ps
`default_nettype none
module sac_chk (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic dg_valid,
    input wire logic [7:0] dg_slave,
    input wire logic [7:0] dg_reg,
    input wire logic dg_crc_ok,
    input wire logic address_select_input_in,
    input wire logic chain_release_output_out,
    input wire logic [7:0] slave_addr_out,
    input wire logic programmed_out,
    input wire logic wr_stb_out,
    input wire logic rd_stb_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // good datagram seen before programming, own or foreign address
    wire logic pre = dg_valid && dg_crc_ok && !programmed_out;
    wire logic pin_eq = dg_slave == {7'h00, address_select_input_in};
    a_no_reply_addr: assert property (dg_valid |-> dg_slave != 8'hff)
        else $error("reply address sent");
    a_crc_good: assert property (dg_valid |-> dg_crc_ok)
        else $error("bad checksum sent");
    a_release_rst: assert property (disable iff (1'h0)
        sys_rst_in |=> chain_release_output_out && !programmed_out)
        else $error("reset state wrong");
    a_pin_write: assert property (pre && pin_eq && dg_reg[7] |=> wr_stb_out)
        else $error("write not taken");
    a_pin_read: assert property (pre && pin_eq && !dg_reg[7] |=> rd_stb_out)
        else $error("read not taken");
    a_foreign_miss: assert property (pre && !pin_eq |=> !wr_stb_out && !rd_stb_out)
        else $error("foreign datagram taken");
    a_release_cause: assert property ($changed(chain_release_output_out) |-> wr_stb_out)
        else $error("release moved without write");
    a_prog_sticks: assert property (programmed_out |=> programmed_out)
        else $error("programmed flag lost");
    a_addr_not_ff: assert property (slave_addr_out != 8'hff)
        else $error("own address is reply address");
endmodule : sac_chk
`default_nettype wire

// >>> verif/slave_address_chaining_bench.sv
/* bench joining master and slave; random regs, data and address.
   assumes the core package, interface and both ends are compiled. */
`timescale 1ns/10ps
`default_nettype none
module slave_address_chaining_bench;
    logic mclk_in = 1'h0, sys_rst_in = 1'h1, req_in = 1'h0, w_r = 1'h0;
    logic pin = 1'h0, rf, rel, prog, wr_stb, rd_stb, hit;
    logic [7:0] s_r = 8'h00, addr, own;
    logic [6:0] r_r = 7'h00, wr_reg, rd_reg;
    logic [31:0] d_r = 32'h0, wr_data;
    logic [15:0] lf = 16'h1db1;
    int err_count = 0, num_checks = 0;
    sac_link_if link ();
    sac_master sac_master_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .link(link), .req_in(req_in), .req_write_in(w_r), .req_slave_in(s_r),
        .req_reg_in(r_r), .req_data_in(d_r), .req_refused_out(rf));
    sac_slave sac_slave_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .link(link), .address_select_input_in(pin),
        .chain_release_output_out(rel), .slave_addr_out(own),
        .programmed_out(prog), .wr_stb_out(wr_stb), .wr_reg_out(wr_reg),
        .wr_data_out(wr_data), .rd_stb_out(rd_stb), .rd_reg_out(rd_reg));
    sac_chk sac_chk_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .dg_valid(link.dg_valid), .dg_slave(link.dg_slave),
        .dg_reg(link.dg_reg), .dg_crc_ok(link.dg_crc_ok),
        .address_select_input_in(pin), .chain_release_output_out(rel),
        .slave_addr_out(own), .programmed_out(prog),
        .wr_stb_out(wr_stb), .rd_stb_out(rd_stb));
    // free running clock
    always #10 mclk_in = ~mclk_in;
    function automatic logic [15:0] nxt_lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt_lf
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // one request, then a bounded watch for the matching strobe
    task automatic xfer(input logic w, input logic [7:0] s,
        input logic [6:0] r, input logic [31:0] d);
        @(negedge mclk_in);
        {req_in, w_r, s_r, r_r, d_r} = {1'h1, w, s, r, d};
        @(negedge mclk_in);
        req_in = 1'h0;
        hit = rf;
        repeat (4) @(negedge mclk_in) hit |= w ? wr_stb : rd_stb;
    endtask : xfer
    initial begin
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in) sys_rst_in = 1'h0;
        cmp("release", 1'h1, rel);
        cmp("programmed", 1'h0, prog);
        for (int p = 0; p < 2; p++) begin
            pin = p[0];
            lf = nxt_lf(lf);
            xfer(1'h0, {7'h00, ~pin}, lf[6:0], 32'h0);
            cmp("miss", 1'h0, hit);
            xfer(1'h0, {7'h00, pin}, lf[6:0], 32'h0);
            cmp("hit", 1'h1, hit);
            cmp("rd_reg", lf[6:0], rd_reg);
        end
        xfer(1'h0, 8'hff, 7'h01, 32'h0);
        cmp("refused", 1'h1, hit);
        lf = nxt_lf(lf);
        addr = 8'h02 + lf[7:0] % 8'hfd;
        xfer(1'h1, 8'h01, 7'h03, {24'h0, addr});
        cmp("release", 1'h0, rel);
        cmp("addr", addr, own);
        xfer(1'h1, addr, {1'h1, lf[13:8]}, {lf, lf});
        cmp("wr_data", {lf, lf}, wr_data);
        cmp("wr_reg", {1'h1, lf[13:8]}, wr_reg);
        xfer(1'h1, 8'h01, 7'h05, 32'h0);
        cmp("old addr", 1'h0, hit);
        xfer(1'h1, addr, 7'h03, 32'h1ff);
        cmp("release", 1'h1, rel);
        cmp("addr kept", addr, own);
        results();
    end
endmodule : slave_address_chaining_bench
`default_nettype wire
